// File: common/irp_pkg.sv
// shared constants and types for the infrared port control/status register slice
package irp_pkg;
  localparam logic [2:0] OFF_DIVLO   = 3'h0;
  localparam logic [2:0] OFF_DIVHI   = 3'h1;
  localparam logic [2:0] OFF_ADVCTL  = 3'h2;
  localparam logic [2:0] OFF_SELCTL  = 3'h3;
  localparam logic [2:0] OFF_HSMODE  = 3'h4;
  localparam logic [2:0] OFF_STATUS  = 3'h5;
  localparam logic [2:0] OFF_RSVD6   = 3'h6;
  localparam logic [2:0] OFF_USER    = 3'h7;

  localparam logic [7:0] SET2_CODE   = 8'he0;
  localparam logic [7:0] SET3_CODE   = 8'he4;
  localparam logic [7:0] SET4_CODE   = 8'he8;
  localparam logic [7:0] SET5_CODE   = 8'hec;
  localparam logic [7:0] SET6_CODE   = 8'hf0;
  localparam logic [7:0] SET7_CODE   = 8'hf4;
  localparam logic [7:0] SEL_READ    = 8'he0;

  localparam int HS_LOOP_BIT   = 4;
  localparam int HS_IRQEN_BIT  = 3;
  localparam int HS_PULSE_BIT  = 4;
  localparam int HS_TXWT_BIT   = 3;
  localparam int HS_DMA_BIT    = 2;
  localparam int ADV_SEL_BIT   = 0;
  localparam int ADV_SWAP_BIT  = 3;
  localparam int DISABLE_FALLBACK_BIT  = 7;
  localparam int US_UNDERRUN_FLAG_BIT  = 6;
  localparam int US_FEND_BIT   = 3;

  localparam logic [7:0] HS_RESET    = 8'h60;
  localparam logic [7:0] ZERO_RESET  = 8'h00;

  localparam int PULSE_NS      = 2000;
  localparam int CLK_NS        = 50;
  localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    AM_RSVD0 = 3'b000, AM_MIRLO = 3'b001, AM_ASK = 3'b010, AM_SIR = 3'b011,
    AM_MIRHI = 3'b100, AM_FIR = 3'b101, AM_CIR = 3'b110, AM_RSVD7 = 3'b111
  } irp_mode_e;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00, PS_ARMED = 2'b01, PS_PULSE = 2'b10
  } irp_pulse_e;

  // receive-side event and level inputs from the datapath
  typedef struct packed {
    logic frameLastAtBottom;
    logic frameTooLong;
    logic illegalSymbol;
    logic crcBad;
    logic overrun;
    logic dataReady;
    logic shiftEmpty;
    logic bufferEmpty;
    logic flowControl;
    logic rxBusy;
    logic frameEndLost;
    logic remotePulse;
    logic frameEndsHeld;
    logic rxTimeout;
    logic statusTimeout;
    logic legacyStatusHi;
  } irp_rx_s;

  // transmit-side inputs
  typedef struct packed {
    logic fifoAtThreshold;
    logic txTimeout;
    logic txRunEmpty;
    logic terminalCount;
    logic frameEnd;
    logic serialOut;
  } irp_tx_s;

  typedef struct packed {
    logic       advanced;
    logic [2:0] mode;
    logic       highSpeed;
    logic       loopback;
    logic       txHold;
    logic       dmaEnable;
    logic       dmaSingle;
    logic       dmaToTx;
    logic       rxFifoBlock;
    logic       decoderAbort;
    logic       frameEndFlag;
  } irp_ctl_s;
endpackage

// File: hw/irp_regs.sv
// infrared port register slice: set select, handshake/mode, status, user/frame status
// Notes on behaviour
// - set select always writable; control only sets 0/1
// - decode written byte into set number
// - legacy loopback forces transmit low, isolates receive
// - legacy interrupt only when enable bit set
// - mode field active only when advanced selected
// - mode field codes select MIR/ASK/SIR/FIR/CIR
// - send pulse emits 2us pulse, self clears
// - transmit wait holds until threshold or timeout
// - DMA enable; single channel direction by swap
// - last byte in frame status reported
// - length exceeded sets flag, blocks receive FIFO
// - illegal symbol sets error, aborts, frame end
// - CRC error sets status bit
// - flow control flag clears on read
// - underrun sets on empty; write one clears
// - bit 5 reports receiver busy
// - lost frame end clears on read
// - remote pulse detect clears on read
// - last byte stays shows held frame ends
// - receive timeout from either FIFO
// - legacy slot seven is scratch register
// - divisor access in advanced mode falls back
// - advanced select bit enters advanced mode
`timescale 1ns/1ns
module irp_regs #(
  parameter int PULSE_CYCLES = irp_pkg::PULSE_CYC
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  // register port
  input  wire logic [2:0]      regAddr,
  input  wire logic [7:0]      regWrData,
  input  wire logic            regWrStb,
  input  wire logic            regRdStb,
  output logic [7:0]           regRdData,
  // datapath status
  input  wire irp_pkg::irp_rx_s rxStat,
  input  wire irp_pkg::irp_tx_s txStat,
  input  wire logic            rxDmaCfg,
  input  wire logic            txDmaCfg,
  input  wire logic            irqRequest,
  // link pins
  input  wire logic            irRxPin,
  output logic                 irTxPin,
  output logic                 irRxData,
  output logic                 irqOut,
  output irp_pkg::irp_ctl_s    ctl
);
  initial begin
    if (PULSE_CYCLES < 1) $error("PULSE_CYCLES must be at least one");
  end

  logic [2:0] setSel_ff;
  logic [7:0] lineCtl_ff;
  logic [7:0] hsMode_ff;
  logic [7:0] scratch_ff;
  logic [7:0] advCtl_ff;
  logic [7:0] advCtl2_ff;
  logic       flowAct_ff;
  logic       underrun_ff;
  logic       lostFe_ff;
  logic       frameEnd_ff;
  logic       lenExc_ff;
  logic       phyErr_ff;
  logic       crcErr_ff;
  logic       rxTo_ff;
  irp_pkg::irp_pulse_e pState_ff;
  logic [$clog2(PULSE_CYCLES+1)-1:0] pCnt_ff;
  logic       txHold_ff;

  function automatic logic [2:0] decodeSet(input logic [7:0] v);
    if (!v[7]) return 3'h0;
    case (v)
      irp_pkg::SET2_CODE: return 3'h2;
      irp_pkg::SET3_CODE: return 3'h3;
      irp_pkg::SET4_CODE: return 3'h4;
      irp_pkg::SET5_CODE: return 3'h5;
      irp_pkg::SET6_CODE: return 3'h6;
      irp_pkg::SET7_CODE: return 3'h7;
      default:            return 3'h1;
    endcase
  endfunction

  function automatic logic isSpeedy(input logic [2:0] m);
    return m == irp_pkg::AM_MIRLO || m == irp_pkg::AM_MIRHI || m == irp_pkg::AM_FIR;
  endfunction

  logic       wr;
  logic       rd;
  logic       advanced;
  logic [2:0] mode;
  logic       fast;
  logic       remote;
  logic       userRead;
  logic       fallback;
  logic       legacySet;

  assign wr        = regWrStb;
  assign rd        = regRdStb;
  assign legacySet = setSel_ff == 3'h0 || setSel_ff == 3'h1;
  assign advanced  = advCtl_ff[irp_pkg::ADV_SEL_BIT];
  assign mode      = advanced ? hsMode_ff[7:5] : 3'h0;
  assign fast      = isSpeedy(mode);
  assign remote    = mode == irp_pkg::AM_CIR;
  assign userRead  = rd && regAddr == irp_pkg::OFF_USER && legacySet;
  // one decoded strobe for each register access that has a side effect
  logic       wrSelCtl;
  logic       wrHsMode;
  logic       wrUser;
  logic       wrScratch;
  logic       wrFrameEnd;
  logic       wrSet2;
  logic       pulseWrite;
  logic       underrunClear;
  logic       divAccess;

  // arming looks at the mode already in force, so mode and pulse take two writes
  assign wrSelCtl      = wr && regAddr == irp_pkg::OFF_SELCTL;
  assign wrHsMode      = wr && regAddr == irp_pkg::OFF_HSMODE && legacySet;
  assign wrUser        = wr && regAddr == irp_pkg::OFF_USER && legacySet;
  assign wrScratch     = wrUser && !advanced;
  assign wrFrameEnd    = wrUser && advanced;
  assign wrSet2        = wr && setSel_ff == 3'h2;
  assign pulseWrite    = fast && wrHsMode && regWrData[irp_pkg::HS_PULSE_BIT];
  assign underrunClear = wrUser && regWrData[irp_pkg::US_UNDERRUN_FLAG_BIT];
  assign divAccess     = (wr || rd) && (regAddr == irp_pkg::OFF_DIVLO || regAddr == irp_pkg::OFF_DIVHI);
  // divisor slots live in set 1; either strobe counts as an access
  assign fallback  = advanced && !advCtl2_ff[irp_pkg::DISABLE_FALLBACK_BIT] && setSel_ff == 3'h1 && divAccess;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      setSel_ff <= 3'h0;
    end else if (wrSelCtl) begin
      setSel_ff <= decodeSet(regWrData);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lineCtl_ff <= irp_pkg::ZERO_RESET;
    end else if (wrSelCtl && legacySet) begin
      lineCtl_ff <= regWrData;
    end
  end

  // handshake/mode: legacy form keeps bits 4,3; advanced form keeps 7..2
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hsMode_ff <= irp_pkg::HS_RESET;
    end else if (fallback) begin
      hsMode_ff[7:5] <= 3'h0;
    end else if (wrHsMode) begin
      if (advanced) begin
        hsMode_ff <= {regWrData[7:2], 2'h0};
      end else begin
        hsMode_ff <= {hsMode_ff[7:5], regWrData[4:3], 3'h0};
      end
    end else if (pState_ff == irp_pkg::PS_ARMED) begin
      hsMode_ff[irp_pkg::HS_PULSE_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      advCtl_ff  <= irp_pkg::ZERO_RESET;
      advCtl2_ff <= irp_pkg::ZERO_RESET;
    end else if (fallback) begin
      advCtl_ff <= {1'b0, advCtl_ff[6], 1'b0, advCtl_ff[4:1], 1'b0};
    end else if (wrSet2) begin
      if (regAddr == irp_pkg::OFF_ADVCTL) advCtl_ff <= {regWrData[7], 1'b0, regWrData[5:0]};
      if (regAddr == irp_pkg::OFF_HSMODE) advCtl2_ff <= {regWrData[7], 1'b0, regWrData[5:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      scratch_ff <= irp_pkg::ZERO_RESET;
    end else if (wrScratch) begin
      scratch_ff <= regWrData;
    end
  end

  // frame end command: written by software after the frame data, dropped once the frame ends
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frameEnd_ff <= 1'b0;
    end else if (wrFrameEnd) begin
      frameEnd_ff <= regWrData[irp_pkg::US_FEND_BIT];
    end else if (txStat.frameEnd) begin
      frameEnd_ff <= 1'b0;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flowAct_ff <= 1'b0;
      lostFe_ff  <= 1'b0;
    end else begin
      flowAct_ff <= (fast && rxStat.flowControl) || (flowAct_ff && !userRead);
      lostFe_ff  <= (fast && rxStat.frameEndLost) || (remote && rxStat.remotePulse) ||
                    (lostFe_ff && !userRead);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      underrun_ff <= 1'b0;
    end else begin
      underrun_ff <= (fast && txStat.txRunEmpty &&
                      (hsMode_ff[irp_pkg::HS_DMA_BIT] ? !txStat.terminalCount : !frameEnd_ff)) ||
                     (underrun_ff && !underrunClear);
    end
  end

  // receive error flags clear when the status register is read; the receive timeout flag clears on a user register read
  logic statusRead;
  assign statusRead = rd && regAddr == irp_pkg::OFF_STATUS && legacySet;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      lenExc_ff <= 1'b0;
      phyErr_ff <= 1'b0;
      crcErr_ff <= 1'b0;
      rxTo_ff   <= 1'b0;
    end else begin
      lenExc_ff <= (fast && rxStat.frameTooLong) || (lenExc_ff && !statusRead);
      phyErr_ff <= (fast && rxStat.illegalSymbol) || (phyErr_ff && !statusRead);
      crcErr_ff <= (fast && rxStat.crcBad) || (crcErr_ff && !statusRead);
      rxTo_ff   <= ((fast || remote) && (rxStat.rxTimeout || rxStat.statusTimeout)) ||
                   (rxTo_ff && !userRead);
    end
  end

  // pulse sequencer: armed by the write, fires after the transmitter's frame end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pState_ff <= irp_pkg::PS_IDLE;
      pCnt_ff   <= '0;
    end else begin
      case (pState_ff)
        irp_pkg::PS_IDLE: begin
          if (pulseWrite) begin
            pState_ff <= irp_pkg::PS_ARMED;
          end
        end
        irp_pkg::PS_ARMED: begin
          if (txStat.frameEnd) begin
            pState_ff <= irp_pkg::PS_PULSE;
            pCnt_ff   <= ($bits(pCnt_ff))'(PULSE_CYCLES - 1);
          end
        end
        irp_pkg::PS_PULSE: begin
          if (pCnt_ff == '0) pState_ff <= irp_pkg::PS_IDLE;
          else pCnt_ff <= pCnt_ff - 1'b1;
        end
        default: pState_ff <= irp_pkg::PS_IDLE;
      endcase
    end
  end

  // transmit wait releases once and stays released until the frame ends
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      txHold_ff <= 1'b1;
    end else if (txStat.frameEnd) begin
      txHold_ff <= 1'b1;
    end else if (txStat.fifoAtThreshold || txStat.txTimeout) begin
      txHold_ff <= 1'b0;
    end
  end

  logic loop;
  assign loop = !advanced && hsMode_ff[irp_pkg::HS_LOOP_BIT];

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irTxPin  <= 1'b0;
      irRxData <= 1'b0;
      irqOut   <= 1'b0;
    end else begin
      irTxPin  <= loop ? 1'b0 : (pState_ff == irp_pkg::PS_PULSE || txStat.serialOut);
      irRxData <= loop ? txStat.serialOut : irRxPin;
      irqOut   <= advanced ? irqRequest : (irqRequest && hsMode_ff[irp_pkg::HS_IRQEN_BIT]);
    end
  end

  always_comb begin
    ctl              = '0;
    ctl.advanced     = advanced;
    ctl.mode         = mode;
    ctl.highSpeed    = fast;
    ctl.loopback     = loop;
    ctl.txHold       = fast && hsMode_ff[irp_pkg::HS_TXWT_BIT] && txHold_ff;
    ctl.dmaEnable    = fast && hsMode_ff[irp_pkg::HS_DMA_BIT];
    ctl.dmaSingle    = rxDmaCfg && !txDmaCfg;
    ctl.dmaToTx      = (rxDmaCfg && !txDmaCfg) ? advCtl_ff[irp_pkg::ADV_SWAP_BIT] : 1'b0;
    ctl.rxFifoBlock  = lenExc_ff;
    ctl.decoderAbort = fast && rxStat.illegalSymbol;
    ctl.frameEndFlag = fast && (rxStat.illegalSymbol || phyErr_ff);
  end

  logic [7:0] statusVal;
  logic [7:0] userVal;
  logic [7:0] rdMux;

  always_comb begin
    if (advanced) begin
      statusVal = {fast && rxStat.frameLastAtBottom, rxStat.shiftEmpty, rxStat.bufferEmpty,
                   lenExc_ff, phyErr_ff, crcErr_ff, rxStat.overrun, rxStat.dataReady};
      userVal   = {flowAct_ff, underrun_ff, (fast || remote) && rxStat.rxBusy, lostFe_ff,
                   frameEnd_ff, 1'b0, fast && rxStat.frameEndsHeld, rxTo_ff};
    end else begin
      statusVal = {rxStat.legacyStatusHi, rxStat.shiftEmpty, rxStat.bufferEmpty, 3'h0,
                   rxStat.overrun, rxStat.dataReady};
      userVal   = scratch_ff;
    end
    rdMux = 8'h00;
    case (regAddr)
      irp_pkg::OFF_SELCTL: begin
        // sets 2 and above show a fixed pattern, so the control byte reads back only in sets 0 and 1
        if (legacySet) begin
          rdMux = lineCtl_ff;
        end else begin
          rdMux = irp_pkg::SEL_READ;
        end
      end
      irp_pkg::OFF_ADVCTL: begin
        if (setSel_ff == 3'h2) begin
          rdMux = advCtl_ff;
        end
      end
      irp_pkg::OFF_HSMODE: begin
        if (setSel_ff == 3'h2) begin
          rdMux = advCtl2_ff;
        end else if (advanced) begin
          rdMux = hsMode_ff;
        end else begin
          // legacy form shows only the loopback and interrupt enable bits
          rdMux = {3'h0, hsMode_ff[4:3], 3'h0};
        end
      end
      irp_pkg::OFF_STATUS: begin
        if (legacySet) begin
          rdMux = statusVal;
        end
      end
      irp_pkg::OFF_USER: begin
        if (legacySet) begin
          rdMux = userVal;
        end
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= 8'h00;
    end else begin
      regRdData <= rd ? rdMux : 8'h00;
    end
  end
endmodule // irp_regs

// File: tb/irp_regs_chk.sv
// port-level assertion checker for the infrared port register slice
`timescale 1ns/1ns
module irp_regs_chk #(
  parameter int PULSE_CYCLES = 40
) (
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_b,
  // register port
  input wire logic              regRdStb,
  input wire logic [7:0]        regRdData,
  // datapath side
  input wire irp_pkg::irp_rx_s  rxStat,
  input wire irp_pkg::irp_tx_s  txStat,
  input wire logic              rxDmaCfg,
  input wire logic              txDmaCfg,
  input wire logic              irqRequest,
  // outputs
  input wire logic              irTxPin,
  input wire logic              irRxData,
  input wire logic              irqOut,
  input wire irp_pkg::irp_ctl_s ctl
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  int hiCnt_ff;
  // counts high samples so a pulse length can be judged on its falling edge
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) hiCnt_ff <= 0;
    else hiCnt_ff <= irTxPin ? hiCnt_ff + 1 : 0;
  end
  rd_idle_zero_a: assert property (!regRdStb |=> regRdData == 8'h00) else $error("read data not zero");
  loop_tx_low_a: assert property (ctl.loopback |=> !irTxPin) else $error("transmit not low in loopback");
  loop_rx_a: assert property (ctl.loopback && $past(ctl.loopback) |-> irRxData == $past(txStat.serialOut))
    else $error("loopback receive path wrong");
  irq_gate_a: assert property (!$past(irqRequest) |-> !irqOut) else $error("interrupt without request");
  pulse_len_a: assert property ($fell(irTxPin) && ctl.highSpeed |-> hiCnt_ff == PULSE_CYCLES)
    else $error("pulse length wrong");
  len_block_a: assert property (ctl.highSpeed && rxStat.frameTooLong |=> ctl.rxFifoBlock)
    else $error("receive fifo not blocked");
  phy_abort_a: assert property (ctl.highSpeed && rxStat.illegalSymbol |-> ctl.decoderAbort ##1 ctl.frameEndFlag)
    else $error("decoder not aborted");
  mode_gate_a: assert property (!ctl.advanced |-> !ctl.highSpeed) else $error("fast mode while legacy");
  dma_fast_a: assert property (ctl.dmaEnable |-> ctl.highSpeed) else $error("dma outside fast modes");
  dma_single_a: assert property (ctl.dmaEnable && rxDmaCfg && !txDmaCfg |-> ctl.dmaSingle)
    else $error("single channel not used");
endmodule // irp_regs_chk

bind irp_regs irp_regs_chk #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .regRdStb(regRdStb), .regRdData(regRdData), .rxStat(rxStat),
  .txStat(txStat), .rxDmaCfg(rxDmaCfg), .txDmaCfg(txDmaCfg), .irqRequest(irqRequest),
  .irTxPin(irTxPin), .irRxData(irRxData), .irqOut(irqOut), .ctl(ctl)
);

// File: tb/irp_xcvr.sv
// behavioural infrared transceiver on the port's link pins
`timescale 1ns/1ns
module irp_xcvr (
  // link
  input  wire logic clk_sys,
  input  wire logic irTxPin,
  output logic      irRxPin,
  // observation
  output int        pulseLen
);
  int run;
  initial begin
    irRxPin = 1'b0;
    pulseLen = 0;
    run = 0;
  end
  // no held level on the receive line, so an isolated input cannot pass by luck
  always @(posedge clk_sys) begin
    irRxPin <= ~irRxPin;
    if (irTxPin) run <= run + 1;
    else if (run != 0) begin
      pulseLen <= run;
      run <= 0;
    end
  end
endmodule // irp_xcvr

// File: tb/tb.sv
// self-checking bench for the infrared port register slice
`timescale 1ns/1ns
module tb;
  localparam int PC = 2;
  logic              clk_sys, rst_b, regWrStb, regRdStb, irqRequest, rxDmaCfg, txDmaCfg;
  logic [2:0]        regAddr;
  logic [7:0]        regWrData, regRdData, d;
  irp_pkg::irp_rx_s  rxStat;
  irp_pkg::irp_tx_s  txStat;
  irp_pkg::irp_ctl_s ctl;
  logic              irRxPin, irTxPin, irRxData, irqOut, sv;
  int                errors, comparisons, pulseLen;
  logic [7:0]        scr[$];
  irp_regs #(.PULSE_CYCLES(PC)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .rxStat(rxStat), .txStat(txStat), .rxDmaCfg(rxDmaCfg), .txDmaCfg(txDmaCfg), .irqRequest(irqRequest),
    .irRxPin(irRxPin), .irTxPin(irTxPin), .irRxData(irRxData), .irqOut(irqOut), .ctl(ctl));
  irp_xcvr i_xcvr (.clk_sys(clk_sys), .irTxPin(irTxPin), .irRxPin(irRxPin), .pulseLen(pulseLen));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= v;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input logic [2:0] a, input logic [7:0] e, input string n);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 chk(n, e, regRdData);
  endtask
  // h is the receive level left standing after the one-cycle event
  task fire(input logic [15:0] v, input logic [5:0] t, input logic [15:0] h = 16'h0000);
    @(posedge clk_sys);
    rxStat <= irp_pkg::irp_rx_s'(v);
    txStat <= irp_pkg::irp_tx_s'(t);
    @(posedge clk_sys);
    rxStat <= irp_pkg::irp_rx_s'(h);
    txStat <= '0;
  endtask
  task test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    errors = 0;
    comparisons = 0;
    rst_b = 1'b0;
    regAddr = 3'h0;
    regWrData = 8'h00;
    {regWrStb, regRdStb, irqRequest, rxDmaCfg, txDmaCfg} = 5'h00;
    rxStat = '0;
    txStat = '0;
    void'($urandom(17));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd(irp_pkg::OFF_HSMODE, irp_pkg::HS_RESET & 8'h18, "hs reset");
    rd(irp_pkg::OFF_STATUS, 8'h00, "status reset");
    wr(irp_pkg::OFF_RSVD6, 8'hff);
    rd(irp_pkg::OFF_RSVD6, 8'h00, "slot six");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(irp_pkg::OFF_USER, d);
      scr.push_back(d);
      rd(irp_pkg::OFF_USER, scr.pop_front(), "scratch");
    end
    wr(irp_pkg::OFF_HSMODE, irp_pkg::HS_RESET | 8'h10);
    repeat (8) begin
      @(posedge clk_sys);
      sv = 1'($urandom);
      txStat.serialOut <= sv;
      @(posedge clk_sys);
      #1 chk("loop rx", {7'h0, sv}, {7'h0, irRxData});
      chk("loop tx", 8'h00, {7'h0, irTxPin});
    end
    txStat.serialOut <= 1'b0;
    wr(irp_pkg::OFF_HSMODE, irp_pkg::HS_RESET);
    irqRequest <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1 chk("irq masked", 8'h00, {7'h0, irqOut});
    chk("rx pass", {7'h0, ~irRxPin}, {7'h0, irRxData});
    wr(irp_pkg::OFF_HSMODE, irp_pkg::HS_RESET | 8'h08);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq enabled", 8'h01, {7'h0, irqOut});
    irqRequest <= 1'b0;
    wr(irp_pkg::OFF_SELCTL, irp_pkg::SET2_CODE);
    rd(irp_pkg::OFF_SELCTL, irp_pkg::SEL_READ, "set two read");
    wr(irp_pkg::OFF_ADVCTL, 8'h01);
    wr(irp_pkg::OFF_SELCTL, 8'h00);
    rd(irp_pkg::OFF_HSMODE, irp_pkg::HS_RESET | 8'h08, "mode kept");
    for (int m = 0; m < 8; m++) begin
      wr(irp_pkg::OFF_HSMODE, {3'(m), 5'h00});
      #1 chk("mode", 8'(m), {5'h0, ctl.mode});
      chk("fast", {7'h0, m == 1 || m == 4 || m == 5}, {7'h0, ctl.highSpeed});
    end
    wr(irp_pkg::OFF_HSMODE, 8'ha0);
    wr(irp_pkg::OFF_HSMODE, 8'hb0);
    fire(16'h0000, 6'h02);
    repeat (PC + 6) @(posedge clk_sys);
    chk("pulse length", 8'(PC), 8'(pulseLen));
    rd(irp_pkg::OFF_HSMODE, 8'ha0, "pulse self clear");
    fire(16'h7000, 6'h00, 16'h8000);
    rd(irp_pkg::OFF_STATUS, 8'h9c, "status flags");
    rd(irp_pkg::OFF_STATUS, 8'h80, "status after read");
    fire(16'h00a4, 6'h00, 16'h0048);
    rd(irp_pkg::OFF_USER, 8'hb3, "user flags");
    rd(irp_pkg::OFF_USER, 8'h22, "user after read");
    fire(16'h0000, 6'h08);
    rd(irp_pkg::OFF_USER, 8'h40, "underrun set");
    rd(irp_pkg::OFF_USER, 8'h40, "underrun held");
    wr(irp_pkg::OFF_USER, 8'h40);
    rd(irp_pkg::OFF_USER, 8'h00, "underrun clear");
    wr(irp_pkg::OFF_USER, 8'h08);
    fire(16'h0000, 6'h08);
    rd(irp_pkg::OFF_USER, 8'h08, "frame end no underrun");
    wr(irp_pkg::OFF_HSMODE, 8'ha8);
    #1 chk("tx hold", 8'h01, {7'h0, ctl.txHold});
    fire(16'h0000, 6'h20);
    #1 chk("tx release", 8'h00, {7'h0, ctl.txHold});
    rxDmaCfg <= 1'b1;
    wr(irp_pkg::OFF_HSMODE, 8'ha4);
    #1 chk("dma single", 8'h06, {5'h0, ctl.dmaEnable, ctl.dmaSingle, ctl.dmaToTx});
    wr(irp_pkg::OFF_SELCTL, 8'h80);
    wr(irp_pkg::OFF_DIVLO, 8'h00);
    #1 chk("fallback", 8'h00, {4'h0, ctl.advanced, ctl.mode});
    wr(irp_pkg::OFF_SELCTL, irp_pkg::SET3_CODE);
    wr(irp_pkg::OFF_SELCTL, 8'h81);
    rd(irp_pkg::OFF_SELCTL, irp_pkg::SET3_CODE, "control kept");
    test_done;
  end
  initial begin
    #(3000 * 50);
    errors++;
    $display("watchdog expired");
    test_done;
  end
endmodule // tb
